// ### rtl/asm_pkg.sv
/*
  Constants and types for the status and mode register block.
  Assumes a single clock domain and a serial link sampled on clk_sys.
*/
package asm_pkg;

  // ==========================================================
  // Register addresses
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_CONFIG = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_IDENT = 3'h4;
  localparam logic [2:0] ADDR_PORT = 3'h5;
  localparam logic [2:0] ADDR_OFFSET = 3'h6;
  localparam logic [2:0] ADDR_GAIN = 3'h7;

  // ==========================================================
  // Register widths and reset values
  localparam int STATUS_W = 8;
  localparam int MODE_W = 16;
  localparam int SHIFT_W = 24;
  localparam int CNT_W = 5;
  localparam logic [7:0] STATUS_RESET = 8'h88;
  localparam logic [15:0] MODE_RESET = 16'h000A;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_24 = 5'h18;
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // ==========================================================
  // Field positions
  localparam int ST_RDY = 7;
  localparam int ST_ERR = 6;
  localparam int ST_CH_W = 3;
  localparam logic [1:0] ST_ZERO_BITS = 2'h0;
  localparam logic ST_ONE_BIT = 1'b1;
  localparam int CMD_RW = 6;
  localparam int CMD_RS_HI = 5;
  localparam int CMD_RS_LO = 3;
  localparam int MD_HI = 15;
  localparam int MD_LO = 13;
  localparam int MD_W = 3;
  localparam int CLK_HI = 7;
  localparam int CLK_LO = 6;
  localparam int CLK_W = 2;
  localparam int FS_HI = 3;
  localparam int FS_LO = 0;
  localparam int FS_W = 4;
  localparam logic [15:0] MODE_KEEP_MASK = 16'hE0CF;

  // ==========================================================
  // Codes
  localparam logic [2:0] MD_CONTINUOUS = 3'h0;
  localparam logic [1:0] CLK_INT = 2'h0;
  localparam logic [1:0] CLK_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  localparam logic [1:0] CLK_EXT_DIV2 = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD = 4'h2,
    ST_WR = 4'h4,
    ST_RD = 4'h8
  } asm_state_t;

  // Bits carried by each register on the link
  function automatic logic [4:0] asm_reg_bits(input logic [2:0] a);
    logic [4:0] n;
    n = BITS_8;
    case (a)
      ADDR_MODE, ADDR_CONFIG: n = BITS_16;
      ADDR_DATA, ADDR_OFFSET, ADDR_GAIN: n = BITS_24;
      default: n = BITS_8;
    endcase
    return n;
  endfunction

endpackage

// ### rtl/asm_shreg.sv
/*
  Parameterised shift register, MSB first, shifting left.
  Assumes load and shift are qualified by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module asm_shreg #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic shift,
  input wire logic sin,
  output logic [W-1:0] q
);
  // ==========================================================
  // Storage
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else if (load) begin
      q <= load_val;
    end else if (shift) begin
      q <= {q[W-2:0], sin};
    end
  end
endmodule
`default_nettype wire

// ### rtl/asm_status_mode.sv
/*
  Status and mode registers behind a 3-wire serial register link.
  Assumes sclk, din and cs_n are synchronous to clk_sys and slower than it;
  the converter core reports results, clamping, channel and power-down.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - Eight-bit status register, read only
// RULE2 - Host reads status with address zero
// RULE3 - Status shifts out bit 7 first
// RULE4 - Status resets to 0x88
// RULE5 - Bits 5,4 read zero, bit 3 one
// RULE6 - Ready low when new result stored
// RULE7 - Ready high after data read, before update
// RULE8 - Ready high on entering power-down
// RULE9 - Output pin also shows ready
// RULE10 - Error updated with the ready flag
// RULE11 - Error set on clamped result
// RULE12 - Error cleared by conversion-starting write
// RULE13 - Bits 2..0 show channel being converted
// RULE14 - Sixteen-bit mode register, address 001, 0x000A
// RULE15 - Mode shifted bit 15 first
// RULE16 - Mode write resets filter, raises ready
// RULE17 - Mode bits 15..13 select operating mode
// RULE18 - Host writes zeros to mode 12..8
// RULE19 - Mode bits 7,6 select clock source
// RULE20 - Clock codes: int, int out, ext, ext/2
// RULE21 - Command byte: zero start, rw, address
// RULE22 - Mode code 000 is continuous, default
// RULE23 - Status read leaves flags unchanged
// RULE24 - Mode 5,4 zero; 3..0 rate, 1010
module asm_status_mode (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  output logic dout_rdy,
  output logic dout_oe,
  input wire logic conv_done,
  input wire logic conv_clamped,
  input wire logic [asm_pkg::ST_CH_W-1:0] conv_channel,
  input wire logic pre_update,
  input wire logic power_down,
  output logic filter_reset,
  output logic [asm_pkg::MD_W-1:0] operating_mode_field,
  output logic continuous_mode,
  output logic [asm_pkg::CLK_W-1:0] timing_source_field,
  output logic clk_pin_drive,
  output logic ext_clk_sel,
  output logic ext_clk_div2,
  output logic [asm_pkg::FS_W-1:0] update_rate_field
);
  import asm_pkg::*;

  // ==========================================================
  // State
  asm_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [4:0] len_q, len_d;
  logic sclk_q, pd_q, rdy_q, rdy_d, err_q, err_d, dout_q, dout_d, oe_q;
  logic filt_q, cont_q, pin_q, ext_q, div2_q;
  logic [ST_CH_W-1:0] ch_q;
  logic [MODE_W-1:0] mode_q, mode_d;
  logic [MODE_W-1:0] rx_q;
  logic [SHIFT_W-1:0] tx_q;

  // ==========================================================
  // Link decode
  wire sclk_rise = !cs_n && sclk && !sclk_q;
  wire sclk_fall = !cs_n && !sclk && sclk_q;
  wire [STATUS_W-1:0] cmd_byte = {rx_q[STATUS_W-2:0], din};
  wire cmd_rw = cmd_byte[CMD_RW];
  wire [ADDR_W-1:0] cmd_addr = cmd_byte[CMD_RS_HI:CMD_RS_LO];
  wire cmd_done = (state_q == ST_CMD) && sclk_rise && (cnt_q == CMD_LAST); // RULE21
  wire last_bit = sclk_rise && (cnt_q == len_q - CNT_ONE);
  wire wr_done = (state_q == ST_WR) && last_bit;
  wire rd_done = (state_q == ST_RD) && last_bit;
  wire mode_wr = wr_done && (addr_q == ADDR_MODE);
  wire [MODE_W-1:0] wr_val = {rx_q[MODE_W-2:0], din}; // RULE15
  wire data_read = rd_done && (addr_q == ADDR_DATA);
  wire pd_rise = power_down && !pd_q;
  wire rdy_set = data_read || pre_update || pd_rise || mode_wr; // RULE7 RULE8 RULE16
  wire tx_load = cmd_done && cmd_rw;
  wire tx_shift = (state_q == ST_RD) && sclk_fall && (cnt_q != '0);

  // Fixed bits are wired, never stored
  wire [STATUS_W-1:0] status_w = {rdy_q, err_q, ST_ZERO_BITS, ST_ONE_BIT, ch_q}; // RULE5 RULE13

  // Reads are MSB aligned; other registers read as zero here
  wire [SHIFT_W-1:0] tx_val =
    (cmd_addr == ADDR_STATUS) ? {status_w, {(SHIFT_W-STATUS_W){1'b0}}} : // RULE3 RULE23
    (cmd_addr == ADDR_MODE) ? {mode_q, {(SHIFT_W-MODE_W){1'b0}}} : // RULE15
    '0;

  // ==========================================================
  // Shift registers
  asm_shreg #(.W(MODE_W)) u_rx (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(cs_n),
    .load_val('0),
    .shift(sclk_rise),
    .sin(din),
    .q(rx_q)
  );

  asm_shreg #(.W(SHIFT_W)) u_tx (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(tx_load),
    .load_val(tx_val),
    .shift(tx_shift),
    .sin(1'b0),
    .q(tx_q)
  );

  // ==========================================================
  // Link sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    len_d = len_q;
    if (cs_n) begin
      state_d = ST_IDLE;
      cnt_d = '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sclk_rise && !din) begin // RULE21
            state_d = ST_CMD;
            cnt_d = CNT_ONE;
          end
        end
        ST_CMD: begin
          if (cmd_done) begin
            addr_d = cmd_addr;
            len_d = asm_reg_bits(cmd_addr);
            cnt_d = '0;
            if (cmd_rw) begin
              state_d = ST_RD;
            end else if (cmd_addr == ADDR_STATUS) begin // RULE1
              state_d = ST_IDLE;
            end else begin
              state_d = ST_WR;
            end
          end else if (sclk_rise) begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
        ST_WR, ST_RD: begin
          if (last_bit) begin
            state_d = ST_IDLE;
            cnt_d = '0;
          end else if (sclk_rise) begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags: a stored result wins over any raising event
  assign rdy_d = conv_done ? 1'b0 : (rdy_set ? 1'b1 : rdy_q); // RULE6 RULE7 RULE8
  assign err_d = conv_done ? conv_clamped : (mode_wr ? 1'b0 : err_q); // RULE10 RULE11 RULE12

  // ==========================================================
  // Mode register
  assign mode_d = mode_wr ? (wr_val & MODE_KEEP_MASK) : mode_q; // RULE14 RULE24

  // Pin shows read data during a read, the ready flag otherwise
  assign dout_d = (state_q == ST_RD) ? tx_q[SHIFT_W-1] : rdy_q; // RULE9

  // ==========================================================
  // Flip-flops
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      addr_q <= ADDR_STATUS;
      len_q <= BITS_8;
      sclk_q <= 1'b1;
      pd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      len_q <= len_d;
      sclk_q <= sclk;
      pd_q <= power_down;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdy_q <= STATUS_RESET[ST_RDY]; // RULE4
      err_q <= STATUS_RESET[ST_ERR];
      ch_q <= STATUS_RESET[ST_CH_W-1:0];
    end else begin
      rdy_q <= rdy_d;
      err_q <= err_d;
      ch_q <= conv_channel; // RULE13
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_RESET; // RULE14 RULE22
      filt_q <= 1'b0;
      cont_q <= 1'b1;
      pin_q <= 1'b0;
      ext_q <= 1'b0;
      div2_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      filt_q <= mode_wr; // RULE16
      cont_q <= mode_d[MD_HI:MD_LO] == MD_CONTINUOUS; // RULE17 RULE22
      pin_q <= mode_d[CLK_HI:CLK_LO] == CLK_INT_OUT; // RULE19 RULE20
      ext_q <= mode_d[CLK_HI:CLK_LO] == CLK_EXT || mode_d[CLK_HI:CLK_LO] == CLK_EXT_DIV2;
      div2_q <= mode_d[CLK_HI:CLK_LO] == CLK_EXT_DIV2; // RULE20
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dout_q <= STATUS_RESET[ST_RDY];
      oe_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q <= !cs_n;
    end
  end

  // ==========================================================
  // Outputs
  assign dout_rdy = dout_q;
  assign dout_oe = oe_q;
  assign filter_reset = filt_q;
  assign operating_mode_field = mode_q[MD_HI:MD_LO]; // RULE17
  assign continuous_mode = cont_q;
  assign timing_source_field = mode_q[CLK_HI:CLK_LO]; // RULE19
  assign clk_pin_drive = pin_q;
  assign ext_clk_sel = ext_q;
  assign ext_clk_div2 = div2_q;
  assign update_rate_field = mode_q[FS_HI:FS_LO]; // RULE24

  // ==========================================================
  // Checks
  a_status_fixed_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
    status_w[5:4] == 2'h0 && status_w[3] == 1'b1)
    else $error("status fixed bits wrong");

  a_status_write_ignored: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    cmd_done && !cmd_rw && cmd_addr == ADDR_STATUS |=> state_q == ST_IDLE)
    else $error("write to status entered data phase");

  a_status_msb_first: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
    tx_load && cmd_addr == ADDR_STATUS |=> tx_q[23:16] == $past(status_w))
    else $error("status not loaded msb first");

  a_rdy_result_clear: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
    conv_done |=> !rdy_q)
    else $error("ready not cleared on new result");

  a_rdy_power_down: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
    $rose(power_down) && !conv_done |=> rdy_q)
    else $error("ready not raised on power-down");

  a_err_clamp_set: assert property (@(posedge clk_sys) disable iff (reset) // RULE11
    conv_done |=> err_q == $past(conv_clamped) && !rdy_q)
    else $error("error flag not written with ready");

  a_mode_write_effects: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
    mode_wr && !conv_done |=> filter_reset && rdy_q && !err_q ##1 !filter_reset)
    else $error("mode write effects wrong");

  a_mode_zero_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE24
    mode_q[12:8] == 5'h00 && mode_q[5:4] == 2'h0)
    else $error("mode reserved bits not zero");

  a_pin_shows_ready: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
    state_q != ST_RD |=> dout_rdy == $past(rdy_q))
    else $error("pin does not follow ready flag");

  a_status_read_quiet: assert property (@(posedge clk_sys) disable iff (reset) // RULE23
    rd_done && addr_q == ADDR_STATUS && !conv_done && !pre_update && !$rose(power_down)
    |=> rdy_q == $past(rdy_q) && err_q == $past(err_q))
    else $error("status read changed flags");

endmodule
`default_nettype wire

// ### sim/asm_host_model.sv
/*
  Host controller model driving the 3-wire register link in mode 3.
  Assumes clk_sys is the block clock; link pins change on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module asm_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic din,
  output logic cs_n,
  input wire logic dout_rdy
);
  // ==========================================================
  // Idle levels: clock parked high, chip deselected
  initial begin
    sclk = 1'b1;
    din = 1'b1;
    cs_n = 1'b1;
  end

  // ==========================================================
  // One frame: command byte then n data bits, MSB first
  task automatic access(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                        output logic [23:0] rd);
    logic [31:0] sh;
    logic [32:0] cap;
    logic [23:0] m;
    sh = {cmd, wd << (24 - n)};
    cap = '0;
    m = (24'h1 << n) - 24'h1;
    @(negedge clk_sys);
    cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      @(negedge clk_sys);
      sclk = 1'b0;
      din = sh[31];
      sh = sh << 1;
      repeat (3) @(negedge clk_sys);
      cap = {cap[31:0], dout_rdy};
      sclk = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
    rd = cap[23:0] & m;
    @(negedge clk_sys);
    cs_n = 1'b1;
    din = ~din;
  endtask
endmodule
`default_nettype wire

// ### sim/tb_asm_status_mode.sv
/*
  Self-checking bench for the status and mode registers.
  Assumes the host model drives the link; converter events come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_asm_status_mode;
  import asm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sclk, din, cs_n, dout_rdy, dout_oe, filter_reset, continuous_mode;
  logic clk_pin_drive, ext_clk_sel, ext_clk_div2;
  logic conv_done = 1'b0;
  logic conv_clamped = 1'b0;
  logic pre_update = 1'b0;
  logic power_down = 1'b0;
  logic [2:0] conv_channel = 3'h0;
  logic [2:0] operating_mode_field;
  logic [1:0] timing_source_field;
  logic [3:0] update_rate_field;
  logic [23:0] v;
  logic [2:0] md;
  int num_errors = 0;
  int n_compared = 0;
  int fr_n = 0;
  int oe_n = 0;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (filter_reset === 1'b1) fr_n <= fr_n + 1;
  always @(posedge clk_sys) if (dout_oe === 1'b1) oe_n <= oe_n + 1;

  asm_host_model host (.clk_sys(clk_sys), .sclk(sclk), .din(din), .cs_n(cs_n),
    .dout_rdy(dout_rdy));
  asm_status_mode dut (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .din(din),
    .cs_n(cs_n), .dout_rdy(dout_rdy), .dout_oe(dout_oe), .conv_done(conv_done),
    .conv_clamped(conv_clamped), .conv_channel(conv_channel), .pre_update(pre_update),
    .power_down(power_down), .filter_reset(filter_reset),
    .operating_mode_field(operating_mode_field), .continuous_mode(continuous_mode),
    .timing_source_field(timing_source_field), .clk_pin_drive(clk_pin_drive),
    .ext_clk_sel(ext_clk_sel), .ext_clk_div2(ext_clk_div2),
    .update_rate_field(update_rate_field));

  // ==========================================================
  // Compare and report
  task automatic chk_reg(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic conclude;
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Register access and events
  task automatic rd_reg(input logic [2:0] a, input int n, output logic [23:0] r);
    host.access({2'b01, a, 3'h0}, n, 24'h0, r);
  endtask
  task automatic wr_reg(input logic [2:0] a, input int n, input logic [23:0] w);
    logic [23:0] junk;
    host.access({2'b00, a, 3'h0}, n, w, junk);
  endtask
  task automatic st(input logic r, input logic e);
    logic [23:0] s;
    rd_reg(ADDR_STATUS, 8, s);
    chk_reg("status", {16'h0, r, e, 2'b00, 1'b1, conv_channel}, s);
    chk_pin("ready pin", r, dout_rdy);
  endtask
  task automatic ev(input int k, input logic cl);
    @(negedge clk_sys);
    conv_done = (k == 0);
    conv_clamped = cl;
    pre_update = (k == 1);
    power_down = (k == 2);
    @(negedge clk_sys);
    conv_done = 1'b0;
    pre_update = 1'b0;
    repeat (3) @(negedge clk_sys);
    power_down = 1'b0;
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    st(1'b1, 1'b0);
    @(negedge clk_sys);
    chk_reg("enable cycles", 24'h71, 24'(oe_n));
    chk_pin("enable idle", 1'b0, dout_oe);
    wr_reg(ADDR_STATUS, 0, 24'h0);
    st(1'b1, 1'b0);
    rd_reg(ADDR_MODE, 16, v);
    chk_reg("mode reset", 24'h00000A, v);
    chk_reg("mode outputs", {3'h0, 1'b1, 2'h0, 3'h0, 4'hA}, {operating_mode_field,
      continuous_mode, timing_source_field, clk_pin_drive, ext_clk_sel, ext_clk_div2,
      update_rate_field});
    for (int c = 0; c < 4; c++) begin
      md = c[2:0];
      wr_reg(ADDR_MODE, 16, {8'h00, md, 5'h00, c[1:0], 6'h35});
      rd_reg(ADDR_MODE, 16, v);
      chk_reg("mode readback", {8'h00, md, 5'h00, c[1:0], 6'h05}, v);
      chk_reg("mode outputs", {md, md == 3'h0, c[1:0], c == 1, c >= 2, c == 3, 4'h5},
        {operating_mode_field, continuous_mode, timing_source_field, clk_pin_drive,
        ext_clk_sel, ext_clk_div2, update_rate_field});
      chk_reg("filter resets", 24'(c + 1), 24'(fr_n));
    end
    conv_channel = 3'h5;
    ev(0, 1'b1);
    st(1'b0, 1'b1);
    st(1'b0, 1'b1);
    wr_reg(ADDR_MODE, 16, 24'h00000A);
    st(1'b1, 1'b0);
    ev(0, 1'b0);
    st(1'b0, 1'b0);
    ev(1, 1'b0);
    st(1'b1, 1'b0);
    conv_channel = 3'h2;
    ev(0, 1'b0);
    ev(2, 1'b0);
    st(1'b1, 1'b0);
    ev(0, 1'b1);
    rd_reg(ADDR_DATA, 24, v);
    chk_reg("data read", 24'h0, v);
    repeat (3) @(negedge clk_sys);
    chk_pin("ready after data read", 1'b1, dout_rdy);
    conclude;
  end
endmodule
`default_nettype wire
